// [inc/acis_pkg.sv]
// package for the converter channel input-select register block
package acis_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] CHAN_IDX_0      = 8'h10;
    localparam logic [7:0] CHAN_IDX_1      = 8'h11;
    localparam logic [7:0] CHAN_IDX_2      = 8'h12;
    localparam logic [7:0] CHAN_IDX_3      = 8'h13;
    localparam int         NUM_CHANNELS    = 4;
    localparam int         ADDR_W          = 10;

    // field positions
    localparam int         NEG_LSB         = 0;
    localparam int         NEG_MSB         = 4;
    localparam int         POS_LSB         = 5;
    localparam int         POS_MSB         = 9;
    localparam int         SETUP_LSB       = 12;
    localparam int         SETUP_MSB       = 13;
    localparam int         ENABLE_BIT      = 15;

    // writable bits: enable, setup, positive and negative selectors
    localparam logic [15:0] CHAN_WR_MASK   = 16'hb3ff;

    // reset values
    localparam logic [15:0] CHAN0_RESET    = 16'h8001;
    localparam logic [15:0] CHAN_RESET     = 16'h0001;

    // source codes shared by both selectors
    localparam logic [4:0] SRC_AIN_LAST    = 5'h04;
    localparam logic [4:0] SRC_TEMP_POS    = 5'h11;
    localparam logic [4:0] SRC_TEMP_NEG    = 5'h12;
    localparam logic [4:0] SRC_SUPPLY_POS  = 5'h13;
    localparam logic [4:0] SRC_SUPPLY_NEG  = 5'h14;
    localparam logic [4:0] SRC_REF_POS     = 5'h15;
    localparam logic [4:0] SRC_REF_NEG     = 5'h16;

    // decoded source classes
    localparam logic [2:0] CLS_AIN         = 3'h0;
    localparam logic [2:0] CLS_TEMP        = 3'h1;
    localparam logic [2:0] CLS_SUPPLY      = 3'h2;
    localparam logic [2:0] CLS_REF         = 3'h3;
    localparam logic [2:0] CLS_INVALID     = 3'h7;

    // bus slave states
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK  = 3'b010,
        BUS_DONE = 3'b100
    } acis_bus_state_t;

    // classify a five-bit selector code
    function automatic logic [2:0] acis_classify(input logic [4:0] code);
        if (code <= SRC_AIN_LAST) begin
            return CLS_AIN;
        end else if (code == SRC_TEMP_POS || code == SRC_TEMP_NEG) begin
            return CLS_TEMP;
        end else if (code == SRC_SUPPLY_POS || code == SRC_SUPPLY_NEG) begin
            return CLS_SUPPLY;
        end else if (code == SRC_REF_POS || code == SRC_REF_NEG) begin
            return CLS_REF;
        end
        return CLS_INVALID;
    endfunction

endpackage

// [core/acis_channel_reg.sv]
// one channel configuration register, output as one 16-bit word; acis_top slices its fields
`timescale 1ns/1ps
`default_nettype none
module acis_channel_reg
    import acis_pkg::*;
#(
    parameter logic [15:0] RESET_VALUE = 16'h0001
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // write port
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    // register contents
    output logic      [15:0] value
);
    // reserved bits masked so they always read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value <= RESET_VALUE;
        end else if (clk_en && wr_en) begin
            value <= wr_data & CHAN_WR_MASK;
        end
    end
endmodule
`default_nettype wire

// [core/acis_top.sv]
// channel input-select register block behind an avalon-mm slave
// Function
// - negative selector bits 4:0, resets to 1
// - selector codes: pins, temp, supply, reference
// - channels 1-3 at 0x11-0x13, reset 0x0001
// - all channels share layout, independent control
// - enable, setup, positive, negative field layout
// - positive selector bits 9:5, resets to 0
// - two-bit setup choice in bits 13:12
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module acis_top (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    // avalon-mm slave
    input  wire logic [acis_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [31:0]                avs_readdata,
    output logic      [1:0]                 avs_response,
    output logic                            avs_waitrequest,
    // per-channel selections toward the converter
    output logic      [3:0]                 channel_enable_bit,
    output logic      [7:0]                 setup_choice,
    output logic      [19:0]                positive_input_select,
    output logic      [19:0]                negative_input_select,
    output logic      [3:0]                 channel_fault
);
    import acis_pkg::*;

    acis_bus_state_t  state;
    logic [15:0]      chan_value [NUM_CHANNELS];
    logic [3:0]       hit;
    logic [3:0]       wr_sel;
    logic [15:0]      merged;
    logic [15:0]      read_word;
    logic             mapped;
    logic [7:0]       index;
    logic             request;
    logic             take;
    // next values of the field outputs
    logic [3:0]       next_enable;
    logic [7:0]       next_setup;
    logic [19:0]      next_pos;
    logic [19:0]      next_neg;
    logic [3:0]       next_fault;
    logic [3:0]       pos_bad;
    logic [3:0]       neg_bad;

    // a selector code that the source table does not name
    function automatic logic code_invalid(input logic [4:0] code);
        return acis_classify(code) == CLS_INVALID;
    endfunction

    // word index from the byte address
    assign index  = avs_address[9:2];
    assign hit[0] = (index == CHAN_IDX_0);
    assign hit[1] = (index == CHAN_IDX_1);
    assign hit[2] = (index == CHAN_IDX_2);
    assign hit[3] = (index == CHAN_IDX_3);
    assign mapped = |hit;

    // taken only from idle, so a request held over the answer is seen once
    assign request = avs_read || avs_write;
    assign take    = (state == BUS_IDLE) && request;

    // read mux of the selected channel
    always_comb begin
        read_word = 16'h0000;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (hit[i]) begin
                read_word = chan_value[i];
            end
        end
    end

    // byte-lane merge; lanes 2 and 3 lie outside the 16-bit register
    always_comb begin
        merged = read_word;
        if (avs_byteenable[0]) begin
            merged[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
            merged[15:8] = avs_writedata[15:8];
        end
    end

    // write happens in the ack cycle, when waitrequest is low
    assign wr_sel = (state == BUS_ACK && avs_write) ? hit : 4'h0;

    // one register per channel, each controlled on its own
    genvar g;
    generate
        for (g = 0; g < NUM_CHANNELS; g++) begin : gen_chan
            acis_channel_reg #(
                .RESET_VALUE (g == 0 ? CHAN0_RESET : CHAN_RESET)
            ) u_chan (
                .clk     (clk),
                .rst_n   (rst_n),
                .clk_en  (clk_en),
                .wr_en   (wr_sel[g]),
                .wr_data (merged),
                .value   (chan_value[g])
            );

            // slice the stored word into its fields
            assign next_enable[g]     = chan_value[g][ENABLE_BIT];
            assign next_setup[2*g+:2] = chan_value[g][SETUP_MSB:SETUP_LSB];
            assign next_pos[5*g+:5]   = chan_value[g][POS_MSB:POS_LSB];
            assign next_neg[5*g+:5]   = chan_value[g][NEG_MSB:NEG_LSB];
            // flag codes outside the table so a stray value is visible
            assign pos_bad[g]         = code_invalid(next_pos[5*g+:5]);
            assign neg_bad[g]         = code_invalid(next_neg[5*g+:5]);
            assign next_fault[g]      = pos_bad[g] || neg_bad[g];
        end
    endgenerate

    // channel enables toward the converter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            channel_enable_bit <= 4'h0;
        end else if (clk_en) begin
            channel_enable_bit <= next_enable;
        end
    end

    // setup choices toward the converter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            setup_choice <= 8'h00;
        end else if (clk_en) begin
            setup_choice <= next_setup;
        end
    end

    // positive input selections toward the converter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            positive_input_select <= 20'h00000;
        end else if (clk_en) begin
            positive_input_select <= next_pos;
        end
    end

    // negative input selections toward the converter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            negative_input_select <= 20'h00000;
        end else if (clk_en) begin
            negative_input_select <= next_neg;
        end
    end

    // fault level, same lag as the fields it describes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            channel_fault <= 4'h0;
        end else if (clk_en) begin
            channel_fault <= next_fault;
        end
    end

    // bus handshake: idle -> ack (waitrequest low one cycle) -> done
    // done forces a release cycle so a held request is not taken twice
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= BUS_IDLE;
        end else if (clk_en) begin
            unique case (state)
                BUS_IDLE: begin
                    if (request) begin
                        state <= BUS_ACK;
                    end
                end
                BUS_ACK:  state <= BUS_DONE;
                BUS_DONE: state <= BUS_IDLE;
                default:  state <= BUS_IDLE;
            endcase
        end
    end

    // waitrequest low for exactly the one answer cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            avs_waitrequest <= !take;
        end
    end

    // read data held until the next request is taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en && take) begin
            avs_readdata <= {16'h0000, read_word};
        end
    end

    // response held with the read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_response <= 2'h0;
        end else if (clk_en && take) begin
            if (mapped) begin
                avs_response <= 2'h0;
            end else begin
                // unmapped: decode error, the write is dropped
                avs_response <= 2'h3;
            end
        end
    end

    // software side obligation: supply-divider codes need buffers on first;
    // this block stores the code as written and leaves sequencing to software
endmodule
`default_nettype wire

// [verification/acis_top_asserts.sv]
// assertion checker for the channel input-select register block
`timescale 1ns/1ps
`default_nettype none
module acis_asserts (
    // bus side
    input wire logic                        clk, rst_n, avs_read, avs_write, avs_waitrequest,
    input wire logic [acis_pkg::ADDR_W-1:0] avs_address,
    input wire logic [31:0]                 avs_writedata, avs_readdata,
    input wire logic [3:0]                  avs_byteenable, channel_enable_bit, channel_fault,
    input wire logic [1:0]                  avs_response,
    // selections toward the converter
    input wire logic [7:0]                  setup_choice,
    input wire logic [19:0]                 positive_input_select, negative_input_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [1:0]  wi;
    logic [15:0] wd;
    wire acc = avs_write && !avs_waitrequest && avs_response == 2'h0 && avs_byteenable == 4'h3;
    // last accepted write; request spacing keeps it valid two cycles on
    always_ff @(posedge clk) begin
        if (acc) begin
            wi <= avs_address[3:2];
            wd <= avs_writedata[15:0];
        end
    end
    // codes outside the source table
    function automatic logic bad(input logic [4:0] c);
        return (c > 5'h04 && c < 5'h11) || c > 5'h16;
    endfunction
    a_neg_field: assert property (acc |-> ##2 negative_input_select[5*wi+:5] == wd[4:0])
        else $error("negative selector not updated");
    a_pos_field: assert property (acc |-> ##2 positive_input_select[5*wi+:5] == wd[9:5])
        else $error("positive selector not updated");
    a_setup_field: assert property (acc |-> ##2 setup_choice[2*wi+:2] == wd[13:12])
        else $error("setup choice not updated");
    a_enable_bit: assert property (acc |-> ##2 channel_enable_bit[wi] == wd[15])
        else $error("channel enable not updated");
    a_other_chan: assert property (acc |-> ##2 ((negative_input_select ^ $past(negative_input_select, 2)) & ~(20'h1f << 5*wi)) == 20'h0)
        else $error("write disturbed another channel");
    a_reset_fields: assert property ($rose(rst_n) |=> negative_input_select == 20'h08421 && positive_input_select == 20'h0 && setup_choice == 8'h0 && channel_enable_bit == 4'h1)
        else $error("field outputs wrong after reset");
    a_read_reserved: assert property (avs_read && !avs_waitrequest |-> (avs_readdata & 32'hffff4c00) == 32'h0)
        else $error("reserved bits read nonzero");
    a_fault_flag: assert property (channel_fault[1] == (bad(negative_input_select[9:5]) || bad(positive_input_select[9:5])))
        else $error("fault flag disagrees with codes");
    cover property (acc);
    cover property (avs_read && !avs_waitrequest);
    cover property (!avs_waitrequest && avs_response == 2'h3);
endmodule
bind acis_top acis_asserts u_chk (.*);
`default_nettype wire

// [verification/acis_top_test.sv]
// self-checking bench for the channel input-select register block
`timescale 1ns/1ps
`default_nettype none
module acis_top_test;
    import acis_pkg::*;
    logic        clk = 0, rst_n = 0, clk_en = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic [3:0]  avs_byteenable = '0, channel_enable_bit, channel_fault;
    logic [1:0]  avs_response, r;
    logic [7:0]  setup_choice;
    logic [19:0] positive_input_select, negative_input_select;
    logic [15:0] d;
    int          failures = 0, samples_checked = 0;
    // eleven table codes, then four outside it
    logic [4:0]  codes [15] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h11, 5'h12, 5'h13, 5'h14,
                                5'h15, 5'h16, 5'h05, 5'h10, 5'h17, 5'h1f};
    acis_top uut (.*);
    initial forever #12.5 clk = ~clk;
    task automatic check(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] wdat, input logic [3:0] be);
        @(posedge clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {16'h0, wdat};
        avs_byteenable <= be;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        r = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic t_reset;
        for (int g = 0; g < 4; g++) begin
            bus(0, 10'h40 + 10'(4*g), 16'h0, 4'hf);
            check("reset value", g == 0 ? {16'h0, CHAN0_RESET} : 32'h1, q);
        end
        check("neg sel", 32'h08421, {12'h0, negative_input_select});
        check("pos sel", 32'h0, {12'h0, positive_input_select});
        $display("t_reset done");
    endtask
    // distinct values per channel, all ones in reserved places
    task automatic t_layout;
        for (int g = 0; g < 4; g++) bus(1, 10'h40 + 10'(4*g), 16'hffff - 16'(g*16'h1111), 4'h3);
        repeat (2) @(posedge clk);
        for (int g = 0; g < 4; g++) begin
            d = (16'hffff - 16'(g*16'h1111)) & CHAN_WR_MASK;
            check("enable", {31'h0, d[15]}, {31'h0, channel_enable_bit[g]});
            check("setup", {30'h0, d[13:12]}, {30'h0, setup_choice[2*g+:2]});
            check("pos field", {27'h0, d[9:5]}, {27'h0, positive_input_select[5*g+:5]});
            check("neg field", {27'h0, d[4:0]}, {27'h0, negative_input_select[5*g+:5]});
            bus(0, 10'h40 + 10'(4*g), 16'h0, 4'hf);
            check("readback", {16'h0, d}, q);
        end
        $display("t_layout done");
    endtask
    // supply codes are only stored here; enabling the buffers lies outside
    task automatic t_codes;
        for (int i = 0; i < 15; i++) begin
            bus(1, 10'h44, {6'h0, codes[i], codes[i]}, 4'h3);
            repeat (2) @(posedge clk);
            check("neg code", {27'h0, codes[i]}, {27'h0, negative_input_select[9:5]});
            check("pos code", {27'h0, codes[i]}, {27'h0, positive_input_select[9:5]});
            check("fault", {31'h0, i > 10}, {31'h0, channel_fault[1]});
        end
        $display("t_codes done");
    endtask
    task automatic t_lanes;
        bus(1, 10'h48, 16'h1234, 4'h2);
        bus(0, 10'h48, 16'h0, 4'hf);
        check("upper lane", 32'h12dd, q);
        bus(1, 10'h50, 16'hffff, 4'h3);
        check("unmapped wr", 32'h3, {30'h0, r});
        bus(0, 10'h50, 16'h0, 4'hf);
        check("unmapped rd", {2'h3, 30'h0}, {r, q[29:0]});
        $display("t_lanes done");
    endtask
    // clock enable low: a held request waits, then completes once enabled
    task automatic t_freeze;
        @(posedge clk);
        clk_en         <= 1'b0;
        avs_address    <= 10'h4c;
        avs_write      <= 1'b1;
        avs_writedata  <= 32'h0000_0005;
        avs_byteenable <= 4'h3;
        repeat (4) @(posedge clk);
        check("frozen waitrequest", 32'h1, {31'h0, avs_waitrequest});
        clk_en <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        repeat (2) @(posedge clk);
        check("neg after freeze", 32'h5, {27'h0, negative_input_select[19:15]});
        $display("t_freeze done");
    endtask
    // reset in mid-run returns every channel to its reset value
    task automatic t_rerst;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_layout;
        t_codes;
        t_lanes;
        t_freeze;
        t_rerst;
        test_done;
    end
    // hang guard, well above the roughly 150 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done;
    end
endmodule
`default_nettype wire
